/* File: core/tmh_params.svh */
`ifndef TMH_PARAMS_SVH
`define TMH_PARAMS_SVH

// ==========================================
// register addresses
`define TMH_ADDR_MODE       16'hff70
`define TMH_ADDR_CYCLE      16'hff71
`define TMH_ADDR_DUTY       16'hff72
`define TMH_ADDR_PORT_DIR   16'hff73
`define TMH_ADDR_PORT_LATCH 16'hff74

// ==========================================
// mode register fields
`define TMH_RUN_BIT       7
`define TMH_CKS_HI        6
`define TMH_CKS_LO        4
`define TMH_MD_HI         3
`define TMH_MD_LO         2
`define TMH_IDLE_BIT      1
`define TMH_OEN_BIT       0

// ==========================================
// field codes
`define TMH_MD_INTERVAL   2'h0
`define TMH_MD_PWM        2'h2
`define TMH_CKS_DIV1      3'h0
`define TMH_CKS_DIV4      3'h1
`define TMH_CKS_DIV16     3'h2
`define TMH_CKS_DIV64     3'h3
`define TMH_CKS_DIV4096   3'h4
`define TMH_CKS_LSO128    3'h5

// ==========================================
// divider widths in bits (divide by 2**n)
`define TMH_SHIFT_DIV4    4'h2
`define TMH_SHIFT_DIV16   4'h4
`define TMH_SHIFT_DIV64   4'h6
`define TMH_SHIFT_DIV4096 4'hc
`define TMH_SHIFT_LSO128  4'h7

// ==========================================
// reset values
`define TMH_RST_MODE      8'h00
`define TMH_RST_CYCLE     8'h00
`define TMH_RST_DUTY      8'h00
`define TMH_RST_PORT_DIR  8'hff
`define TMH_RST_LATCH     8'h00

`endif

/* File: core/tmh_pkg.sv */
package tmh_pkg;
  typedef logic [7:0] tmh_byte_t;
  typedef enum logic {TMH_TGT_CYCLE, TMH_TGT_DUTY} tmh_target_t;
endpackage

/* File: core/tmh_prescaler.sv */
`timescale 1ns/100ps
`include "tmh_params.svh"

module tmh_prescaler
  import tmh_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  input  wire logic       lso_clk,
  output logic            tick
);

  // ==========================================
  // low-speed oscillator synchroniser
  logic        lso_meta;
  logic        lso_sync;
  logic        lso_prev;
  logic        lso_rise;
  logic [11:0] div_cnt;
  logic [11:0] next_div_cnt;
  logic [11:0] lso_cnt;
  logic [11:0] next_lso_cnt;
  logic        next_tick;

  // true when the low n bits of v are all ones
  function automatic logic low_ones(input logic [11:0] v, input logic [3:0] n);
    logic [11:0] m;
    m = ~(12'hfff << n);
    low_ones = ((v & m) == m);
  endfunction

  assign lso_rise = lso_sync & ~lso_prev;

  // ==========================================
  // dividers
  always_comb
  begin
    next_div_cnt = div_cnt;
    next_lso_cnt = lso_cnt;
    next_tick    = 1'b0;
    if (!run)
    begin
      // dividers restart with the timer so the first period is whole
      next_div_cnt = 12'h000;
      next_lso_cnt = 12'h000;
    end
    else
    begin
      next_div_cnt = div_cnt + 12'h001;
      if (lso_rise)
        next_lso_cnt = lso_cnt + 12'h001;
      case (sel) // R7
        `TMH_CKS_DIV1:    next_tick = 1'b1;
        `TMH_CKS_DIV4:    next_tick = low_ones(div_cnt, `TMH_SHIFT_DIV4);
        `TMH_CKS_DIV16:   next_tick = low_ones(div_cnt, `TMH_SHIFT_DIV16);
        `TMH_CKS_DIV64:   next_tick = low_ones(div_cnt, `TMH_SHIFT_DIV64);
        `TMH_CKS_DIV4096: next_tick = low_ones(div_cnt, `TMH_SHIFT_DIV4096);
        `TMH_CKS_LSO128:  next_tick = lso_rise && low_ones(lso_cnt, `TMH_SHIFT_LSO128);
        default:          next_tick = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      lso_meta <= 1'b0;
      lso_sync <= 1'b0;
      lso_prev <= 1'b0;
      div_cnt  <= 12'h000;
      lso_cnt  <= 12'h000;
      tick     <= 1'b0;
    end
    else if (ce)
    begin
      lso_meta <= lso_clk;
      lso_sync <= lso_meta;
      lso_prev <= lso_sync;
      div_cnt  <= next_div_cnt;
      lso_cnt  <= next_lso_cnt;
      tick     <= next_tick;
    end
  end

endmodule

/* File: core/tmh_timer.sv */
`timescale 1ns/100ps
`include "tmh_params.svh"

// Behaviour
// R1: reset clears cycle and duty compare to zero; both are byte read/write.
// R2: software leaves cycle compare alone while the counter runs.
// R3: duty writes while running take effect at the next old-value match.
// R4: a duty write coinciding with a match waits for the following match.
// R5: in pulse-width mode software rewrites duty compare on every restart.
// R6: run bit 7; clearing stops and zeroes counter, setting starts counting.
// R7: clock select: fxp /1, /4, /16, /64, /4096, or low-speed osc /128.
// R8: mode 00 is interval, 10 is pulse-width; other codes not programmed.
// R9: idle output level bit sets the inactive output level, 0 low, 1 high.
// R10: interval mode with output enable drives a 50 percent square wave.
// R11: software changes no other mode bit while the run bit is set.
// R12: interval match with cycle compare raises interrupt and clears counter.
// R13: interval mode ignores duty compare completely.
// R14: counting begins within one count clock after run is set.
// R15: each interval match also inverts the output level.
// R16: stopping forces interrupt and output inactive, else levels stay.
// R17: software clears pin direction and latch to route the timer output.
// R18: port direction bit 0 output, 1 input; resets to all ones.
// R19: pwm cycle match clears counter, interrupts, output active, targets duty.
// R20: pwm duty match makes output inactive, targets cycle, no clear or interrupt.
// R21: software leaves three count clocks between duty write and next match.
// R22: eight-bit counter increments per count clock, held while stopped.
// R23: duty writes wait in a pending buffer until the transfer point.

module tmh_timer
  import tmh_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        CE,
  input  wire logic [15:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  input  wire logic        LSO_CLK,
  output logic             MATCH_INT,
  output logic             TIMER_OUT,
  output logic      [7:0]  PORT2_DIR,
  output logic             PIN0_OUT,
  output logic             PIN0_OE
);

  // ==========================================
  // declarations
  tmh_byte_t   mode;
  tmh_byte_t   next_mode;
  tmh_byte_t   cycle_compare;
  tmh_byte_t   next_cycle_compare;
  tmh_byte_t   duty_compare;
  tmh_byte_t   next_duty_compare;
  tmh_byte_t   port_dir;
  tmh_byte_t   next_port_dir;
  tmh_byte_t   port_latch;
  tmh_byte_t   next_port_latch;
  tmh_byte_t   next_rdata;
  tmh_byte_t   cnt;
  tmh_byte_t   next_cnt;
  tmh_byte_t   duty_act;
  tmh_byte_t   next_duty_act;
  tmh_target_t target;
  tmh_target_t next_target;
  logic        pend;
  logic        next_pend;
  logic        act;
  logic        next_act;
  logic        skip;
  logic        next_skip;
  logic        next_int;
  logic        next_tout;
  logic        next_pin_out;
  logic        next_pin_oe;
  logic        tick;
  logic        run;
  logic        pwm;
  logic        idle;
  logic        oen;
  logic        wr_mode;
  logic        wr_cycle;
  logic        wr_duty;
  logic        wr_dir;
  logic        wr_latch;
  logic        cyc_hit;
  logic        duty_hit;

  // ==========================================
  // helpers
  // full address decode: a partial one would alias the port registers
  function automatic logic wr_to(input logic w, input logic [15:0] a, input logic [15:0] r);
    wr_to = w && (a == r);
  endfunction

  // a compare counts only on a live count tick, never on the masked first one
  function automatic logic live_match(input logic t, input logic s, input tmh_byte_t c, input tmh_byte_t v);
    live_match = t && !s && (c == v);
  endfunction

  assign run      = mode[`TMH_RUN_BIT];
  assign pwm      = (mode[`TMH_MD_HI:`TMH_MD_LO] == `TMH_MD_PWM); // R8
  assign idle     = mode[`TMH_IDLE_BIT];
  assign oen      = mode[`TMH_OEN_BIT];
  assign wr_mode  = wr_to(WR, ADDR, `TMH_ADDR_MODE);
  assign wr_cycle = wr_to(WR, ADDR, `TMH_ADDR_CYCLE);
  assign wr_duty  = wr_to(WR, ADDR, `TMH_ADDR_DUTY);
  assign wr_dir   = wr_to(WR, ADDR, `TMH_ADDR_PORT_DIR);
  assign wr_latch = wr_to(WR, ADDR, `TMH_ADDR_PORT_LATCH);

  // compare only against the current target; duty is never a target in interval mode
  assign cyc_hit  = live_match(tick, skip, cnt, cycle_compare) && (!pwm || target == TMH_TGT_CYCLE);
  assign duty_hit = live_match(tick, skip, cnt, duty_act) && pwm && target == TMH_TGT_DUTY; // R13

  // ==========================================
  // count clock
  tmh_prescaler u_prescaler
  (
    .clk     (CLK),
    .nrst    (NRST),
    .ce      (CE),
    .run     (run),
    .sel     (mode[`TMH_CKS_HI:`TMH_CKS_LO]),
    .lso_clk (LSO_CLK),
    .tick    (tick)
  );

  // ==========================================
  // register file
  always_comb
  begin
    next_mode          = mode;
    next_cycle_compare = cycle_compare;
    next_duty_compare  = duty_compare;
    next_port_dir      = port_dir;
    next_port_latch    = port_latch;
    next_rdata         = RDATA;
    if (wr_mode)
      next_mode = WDATA;
    if (wr_cycle)
      next_cycle_compare = WDATA; // R1
    if (wr_duty)
      next_duty_compare = WDATA; // R1
    if (wr_dir)
      next_port_dir = WDATA; // R18
    if (wr_latch)
      next_port_latch = WDATA;
    if (RD)
    begin
      case (ADDR)
        `TMH_ADDR_MODE:       next_rdata = mode;
        `TMH_ADDR_CYCLE:      next_rdata = cycle_compare;
        `TMH_ADDR_DUTY:       next_rdata = duty_compare;
        `TMH_ADDR_PORT_DIR:   next_rdata = port_dir;
        `TMH_ADDR_PORT_LATCH: next_rdata = port_latch;
        default:              next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      mode          <= `TMH_RST_MODE;
      cycle_compare <= `TMH_RST_CYCLE; // R1
      duty_compare  <= `TMH_RST_DUTY; // R1
      port_dir      <= `TMH_RST_PORT_DIR; // R18
      port_latch    <= `TMH_RST_LATCH;
      RDATA         <= 8'h00;
    end
    else if (CE)
    begin
      mode          <= next_mode;
      cycle_compare <= next_cycle_compare;
      duty_compare  <= next_duty_compare;
      port_dir      <= next_port_dir;
      port_latch    <= next_port_latch;
      RDATA         <= next_rdata;
    end
  end

  // ==========================================
  // counter and compare sequencing
  always_comb
  begin
    next_cnt      = cnt;
    next_target   = target;
    next_act      = act;
    next_skip     = skip;
    next_pend     = pend;
    next_duty_act = duty_act;
    next_int      = 1'b0;
    // duty write: buffer it; set wins over the duty-match transfer, not the interval or stop ones
    if (wr_duty)
      next_pend = 1'b1; // R23
    // interval mode never compares duty, so take it at once;
    // kept apart from the tick branch so a write never costs a count
    if (run && !pwm && wr_duty)
    begin
      next_duty_act = WDATA;
      next_pend     = 1'b0;
    end
    if (!run)
    begin
      // stop: counter zero, output and interrupt back to inactive
      next_cnt    = 8'h00; // R6
      next_act    = 1'b0; // R16
      next_target = TMH_TGT_CYCLE;
      next_skip   = 1'b1;
      if (wr_duty)
      begin
        next_duty_act = WDATA;
        next_pend     = 1'b0;
      end
    end
    else if (tick)
    begin
      if (skip)
        next_skip = 1'b0; // R14
      else if (cyc_hit)
      begin
        next_cnt = 8'h00; // R12
        next_int = 1'b1; // R12
        if (pwm)
        begin
          next_act    = 1'b1; // R19
          next_target = TMH_TGT_DUTY; // R19
        end
        else
          next_act = ~act; // R15
      end
      else if (duty_hit)
      begin
        next_cnt    = cnt + 8'h01; // R20
        next_act    = 1'b0; // R20
        next_target = TMH_TGT_CYCLE; // R20
        if (pend && !wr_duty) // R4
        begin
          next_duty_act = duty_compare; // R3
          next_pend     = 1'b0; // R3
        end
        // a write in this very cycle keeps pend set for the following match
      end
      else
        next_cnt = cnt + 8'h01; // R22
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      cnt      <= 8'h00;
      target   <= TMH_TGT_CYCLE;
      act      <= 1'b0;
      skip     <= 1'b1;
      pend     <= 1'b0;
      duty_act <= `TMH_RST_DUTY;
      MATCH_INT <= 1'b0;
    end
    else if (CE)
    begin
      cnt       <= next_cnt;
      target    <= next_target;
      act       <= next_act;
      skip      <= next_skip;
      pend      <= next_pend;
      duty_act  <= next_duty_act;
      MATCH_INT <= next_int;
    end
  end

  // ==========================================
  // output pin
  always_comb
  begin
    // disabled output rests at the idle level; active level is its inverse
    next_tout    = oen ? (idle ^ next_act) : idle; // R9 R10
    // latch must read zero for the timer level to reach the pin
    next_pin_out = port_latch[0] | next_tout;
    next_pin_oe  = ~next_port_dir[0]; // R18
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      TIMER_OUT <= 1'b0;
      PIN0_OUT  <= 1'b0;
      PIN0_OE   <= 1'b0;
      PORT2_DIR <= `TMH_RST_PORT_DIR;
    end
    else if (CE)
    begin
      TIMER_OUT <= next_tout;
      PIN0_OUT  <= next_pin_out;
      PIN0_OE   <= next_pin_oe;
      PORT2_DIR <= next_port_dir;
    end
  end

endmodule

/* File: tb/tmh_pin_load.sv */
`timescale 1ns/100ps
// ==========
// pin load: a pull-down holds the pin low once the buffer is off
module tmh_pin_load
(
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      pin_level
);
  assign pin_level = pin_oe ? pin_out : 1'b0;
endmodule

/* File: tb/tmh_timer_asserts.sv */
`timescale 1ns/100ps
module tmh_timer_asserts
(
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        CE,
  input  wire logic [15:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  input  wire logic [7:0]  RDATA,
  input  wire logic        MATCH_INT,
  input  wire logic        TIMER_OUT,
  input  wire logic [7:0]  PORT2_DIR,
  input  wire logic        PIN0_OUT,
  input  wire logic        PIN0_OE
);
  // ==========
  // shadow of mode and latch bit, rebuilt from bus writes
  logic       mwr;
  logic [7:0] mode;
  logic [7:0] next_mode;
  logic       latch0;
  logic       next_latch0;
  logic [1:0] still;
  logic [1:0] next_still;
  assign mwr = CE && WR && ADDR == 16'hff70;
  always_comb
  begin
    next_mode   = mwr ? WDATA : mode;
    next_latch0 = (CE && WR && ADDR == 16'hff74) ? WDATA[0] : latch0;
    // any mode write restarts the settle count, so idle changes get time too
    next_still  = (mwr || mode[7]) ? 2'h0 : still + {1'b0, still != 2'h3};
  end
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      mode   <= 8'h00;
      latch0 <= 1'b0;
      still  <= 2'h0;
    end
    else
    begin
      mode   <= next_mode;
      latch0 <= next_latch0;
      still  <= next_still;
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  property p_rst;
    $rose(NRST) |-> PORT2_DIR == 8'hff && !MATCH_INT && !TIMER_OUT && !PIN0_OE;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_oe;
    $changed(PORT2_DIR[0]) |-> ##[0:1] PIN0_OE == !PORT2_DIR[0];
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable not from direction");
  property p_stop;
    // a pulse launched at the stopping edge itself is still legal
    mwr && !WDATA[7] |=> ##1 !MATCH_INT [*4];
  endproperty
  a_stop: assert property (p_stop) else $error("match while stopped");
  property p_idle;
    still == 2'h3 |-> TIMER_OUT == mode[1] && !MATCH_INT;
  endproperty
  a_idle: assert property (p_idle) else $error("stopped output not idle");
  property p_run;
    MATCH_INT |-> mode[7] || $past(mode[7]);
  endproperty
  a_run: assert property (p_run) else $error("match without run");
  property p_tog;
    MATCH_INT && mode[0] |-> $changed(TIMER_OUT);
  endproperty
  a_tog: assert property (p_tog) else $error("no output edge at match");
  property p_pin;
    $changed(TIMER_OUT) && PIN0_OE && !latch0 |-> ##[0:1] PIN0_OUT == TIMER_OUT;
  endproperty
  a_pin: assert property (p_pin) else $error("pin not following output");
  property p_rd;
    RD && CE && ADDR == 16'hff70 |=> RDATA == $past(mode);
  endproperty
  a_rd: assert property (p_rd) else $error("mode readback wrong");
endmodule

bind tmh_timer tmh_timer_asserts u_chk
(
  .CLK(CLK), .NRST(NRST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .MATCH_INT(MATCH_INT), .TIMER_OUT(TIMER_OUT),
  .PORT2_DIR(PORT2_DIR), .PIN0_OUT(PIN0_OUT), .PIN0_OE(PIN0_OE)
);

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top
  import tmh_pkg::*;
;
  logic        clk = 1'b0, nrst = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0, lso = 1'b0;
  logic [15:0] addr = 16'h0000;
  tmh_byte_t   wdata = 8'h00, rdata, dir;
  logic        mint, tout, pout, poe, lvl;
  int          failures = 0, samples_checked = 0;

  always #25 clk = ~clk;
  // oscillator kept off the main clock phase
  initial #13 forever #100 lso = ~lso;

  tmh_timer u_dut
  (
    .CLK(clk), .NRST(nrst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .LSO_CLK(lso), .MATCH_INT(mint), .TIMER_OUT(tout),
    .PORT2_DIR(dir), .PIN0_OUT(pout), .PIN0_OE(poe)
  );
  tmh_pin_load u_load (.pin_out(pout), .pin_oe(poe), .pin_level(lvl));

  // ==========
  // shared tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input tmh_byte_t d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, output tmh_byte_t d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_int(output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end
    while (mint !== 1'b1 && n < 20000);
    if (n >= 20000)
      chk("match wait", 16'h0001, 16'h0000);
  endtask
  task automatic high_len(output int n);
    n = 1;
    while (tout === 1'b1 && n < 300)
    begin
      @(posedge clk);
      #1 n += (tout === 1'b1);
    end
  endtask

  // ==========
  // scenarios
  task automatic t_reset;
    tmh_byte_t   v;
    logic [15:0] a [6] = '{16'hff70, 16'hff71, 16'hff72, 16'hff73, 16'hff74, 16'hff7f};
    tmh_byte_t   e [6] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++)
    begin
      rd_reg(a[i], v);
      chk("reset value", e[i], v);
    end
    chk("dir port", 8'hff, dir);
  endtask
  task automatic t_regs;
    tmh_byte_t v;
    wr_reg(16'hff71, 8'h5a);
    wr_reg(16'hff72, 8'ha5);
    wr_reg(16'hff7f, 8'h33);
    rd_reg(16'hff71, v);
    chk("cycle", 8'h5a, v);
    rd_reg(16'hff72, v);
    chk("duty", 8'ha5, v);
    rd_reg(16'hff7f, v);
    chk("unmapped", 8'h00, v);
    wr_reg(16'hff73, 8'hfe);
    wr_reg(16'hff74, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("pin enable", 1'b1, poe);
  endtask
  task automatic t_interval;
    int n;
    wr_reg(16'hff71, 8'h03);
    wr_reg(16'hff72, 8'h00);
    wr_reg(16'hff70, 8'h81);
    wait_int(n);
    chk("first match", 1'b1, n >= 5 && n <= 7);
    chk("output inverted", 1'b1, tout);
    for (int i = 0; i < 3; i++)
    begin
      wait_int(n);
      chk("interval period", 16'd4, n[15:0]);
      chk("output toggles", i[0], tout);
    end
    // freeze for three cycles one count into a period: the period stretches by three
    @(posedge clk);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    wait_int(n);
    chk("frozen count", 16'd3, n[15:0]);
    // a duty match at count zero would drop the output here
    @(posedge clk);
    #1 chk("duty ignored", 1'b1, tout);
    chk("pin level", 1'b1, lvl);
    wr_reg(16'hff70, 8'h01);
    n = 0;
    repeat (12)
    begin
      @(posedge clk);
      #1 n += (mint !== 1'b0);
    end
    chk("stopped", 16'd0, n[15:0]);
    chk("stop level", 1'b0, tout);
    wr_reg(16'hff70, 8'h03);
    repeat (2) @(posedge clk);
    #1 chk("idle high", 1'b1, tout);
    wr_reg(16'hff70, 8'h80);
    // one match: a live output would have toggled high by now
    wait_int(n);
    chk("output disabled", 1'b0, tout);
    wr_reg(16'hff70, 8'h00);
  endtask
  task automatic t_clock;
    int n;
    int exp [6] = '{2, 8, 32, 128, 8192, 1024};
    wr_reg(16'hff71, 8'h01);
    for (int c = 0; c < 6; c++)
    begin
      wr_reg(16'hff70, {1'b1, 3'(c), 4'h1});
      wait_int(n);
      wait_int(n);
      // the slow oscillator crosses a synchroniser, so allow one cycle of jitter
      chk("clock period", exp[c], (c == 5 && n >= 1023 && n <= 1025) ? 1024 : n);
      wr_reg(16'hff70, 8'h01);
    end
  endtask
  task automatic t_pwm;
    int n;
    wr_reg(16'hff71, 8'h05);
    wr_reg(16'hff70, 8'h09);
    wr_reg(16'hff72, 8'h02);
    wr_reg(16'hff70, 8'h89);
    wait_int(n);
    wait_int(n);
    chk("pwm period", 16'd6, n[15:0]);
    chk("active at cycle match", 1'b1, tout);
    high_len(n);
    chk("active width", 16'd3, n[15:0]);
    chk("no match at duty", 1'b0, mint);
    wr_reg(16'hff72, 8'h03);
    wait_int(n);
    high_len(n);
    chk("old duty kept", 16'd3, n[15:0]);
    wait_int(n);
    high_len(n);
    chk("new duty used", 16'd4, n[15:0]);
    // rewrite landing on the duty match itself: adopted one match later
    repeat (4) @(posedge clk);
    wr_reg(16'hff72, 8'h01);
    wait_int(n);
    high_len(n);
    chk("coinciding write waits", 16'd4, n[15:0]);
    wait_int(n);
    high_len(n);
    chk("late write used", 16'd2, n[15:0]);
    wait_int(n);
    wr_reg(16'hff70, 8'h09);
    repeat (2) @(posedge clk);
    #1 chk("forced inactive", 1'b0, tout);
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_regs;
    t_interval;
    t_clock;
    t_pwm;
    finish_test;
  end
  initial
  begin
    #4000000;
    failures++;
    finish_test;
  end
endmodule
